// [adcr_pkg.sv]
// package for the converter sequencing and readout block
// assumes a 20 MHz system clock; used by adcr_top
package adcr_pkg;
    // =====================================================
    // clock and timing
    localparam int CLK_MHZ = 20;
    localparam int CONV_FAST_NS = 1470; // fast grade conversion
    localparam int CONV_STD_NS = 1600; // standard grade conversion
    localparam int DONE_NS = 100; // done pulse width
    localparam int ACQ_FAST_NS = 200; // host acquisition wait
    localparam int ACQ_STD_NS = 400;
    // longest times round down, at least one cycle
    localparam int CONV_FAST_CYC = (CONV_FAST_NS * CLK_MHZ) / 1000;
    localparam int CONV_STD_CYC = (CONV_STD_NS * CLK_MHZ) / 1000;
    localparam int DONE_CYC = (DONE_NS * CLK_MHZ) / 1000;
    localparam logic [5:0] CONV_FAST_Q = 6'(CONV_FAST_CYC);
    localparam logic [5:0] CONV_STD_Q = 6'(CONV_STD_CYC);
    localparam logic [2:0] DONE_Q = 3'(DONE_CYC);
    // =====================================================
    // data layout
    localparam int RES_W = 12; // result width
    localparam int SER_BITS = 16; // bits per serial frame
    localparam int LEAD_ZEROS = 4;
    localparam int FIFO_DEPTH = 32;
    localparam logic [RES_W-1:0] RES_RESET = 12'h000;
    localparam logic [4:0] SER_FRAME = 5'h10;
    // =====================================================
    // conversion states
    typedef enum logic [1:0] {
        ADCR_IDLE = 2'b00,
        ADCR_CONV = 2'b01,
        ADCR_DONE = 2'b10
    } adcr_state_t;
endpackage : adcr_pkg

// [adcr_fifo.sv]
// first-in first-out buffer for conversion samples
// assumes one clock; source and sink each use valid/ready
`timescale 1ns/1ps
module adcr_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH]; // sample storage
    logic [AW-1:0] wr_q; // write pointer
    logic [AW-1:0] rd_q; // read pointer
    logic [AW:0] cnt_q; // fill count
    logic push;
    logic pop;

    // =====================================================
    // handshakes; full and empty come from the count
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage write, no reset needed on data
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= AW'(wr_q + 1'b1);
            end
            if (pop) begin
                rd_q <= AW'(rd_q + 1'b1);
            end
            cnt_q <= (AW+1)'(cnt_q + push - pop);
        end
    end
endmodule : adcr_fifo

// [adcr_top.sv]
// conversion sequencer and parallel / serial readout of a 12-bit ADC
// assumes host pins are asynchronous to clk_sys and the analog core
// delivers a result word on conv_result when conversion ends
//
// What this block does
// - trigger rising edge: hold, start conversion
// - conversion ends within 1.47 or 1.6 us
// - end: load result, pulse done low, track
// - supports 600 or 500 kSPS trigger rates
// - mode pin high selects parallel port
// - cs and rd low drive 12-bit result
// - done may drive cs and rd directly
// - mode pin low selects serial port
// - sixteen bits: four zeros, result msb first
// - serial bit changes on shift clock rise
// - after read, release on first rising edge
// - done pulse active low about 100 ns
// - two's complement or straight binary coding
// - parallel data outputs enabled only with cs, rd low
`timescale 1ns/1ps
module adcr_top (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic fast_grade, // 1: fast grade timing
    input wire logic unipolar_grade, // 1: straight binary coding
    input wire logic [11:0] conv_result, // analog core, two's compl.
    input wire logic sample_trigger,
    input wire logic mode_pin, // 1 parallel, 0 serial
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic shift_clk,
    input wire logic serial_frame_strobe_n,
    output logic done_n,
    output logic hold_q, // 1 hold, 0 track
    output logic [11:0] par_data_o,
    output logic par_data_oe,
    output logic serial_out_line_o,
    output logic serial_out_line_oe,
    output logic [11:0] stream_data,
    output logic stream_valid,
    input wire logic stream_ready,
    output logic overrun_q // sample lost, fifo full
);
    // =====================================================
    // pin synchronisers: two flops, first read only by second
    logic [5:0] meta_q; // first stage
    logic [5:0] sync_q; // second stage
    logic [5:0] prev_q; // for edge detection
    logic [5:0] pins;
    assign pins = {sample_trigger, mode_pin, cs_n, rd_n, shift_clk,
                   serial_frame_strobe_n};

    // two-stage capture of all asynchronous pins
    // reset to the idle levels (cs, rd, frame high, clock low) so
    // that no false edge is seen on the first cycles after reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_q <= 6'h0D;
            sync_q <= 6'h0D;
            prev_q <= 6'h0D;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    logic trig_rise;
    logic par_mode;
    logic cs_s;
    logic rd_s;
    logic sclk_rise;
    logic frame_s;
    logic frame_rise;
    logic frame_fall;
    assign trig_rise = sync_q[5] && !prev_q[5];
    assign par_mode = sync_q[4];
    assign cs_s = sync_q[3];
    assign rd_s = sync_q[2];
    assign sclk_rise = sync_q[1] && !prev_q[1];
    assign frame_s = sync_q[0];
    assign frame_rise = sync_q[0] && !prev_q[0];
    assign frame_fall = !sync_q[0] && prev_q[0];

    // =====================================================
    // conversion sequencer
    adcr_pkg::adcr_state_t state_q;
    logic [5:0] conv_cnt_q; // cycles left in conversion
    logic [2:0] done_cnt_q; // cycles left in done pulse
    logic [11:0] result_q; // output register
    logic conv_end;
    assign conv_end = (state_q == adcr_pkg::ADCR_CONV)
                      && (conv_cnt_q == 6'h01);

    // state walk: idle, convert, done pulse
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= adcr_pkg::ADCR_IDLE;
            conv_cnt_q <= 6'h00;
            done_cnt_q <= 3'h0;
        end else begin
            unique case (state_q)
                adcr_pkg::ADCR_IDLE: begin
                    if (trig_rise) begin
                        state_q <= adcr_pkg::ADCR_CONV;
                        conv_cnt_q <= fast_grade ? adcr_pkg::CONV_FAST_Q
                                                 : adcr_pkg::CONV_STD_Q;
                    end
                end
                adcr_pkg::ADCR_CONV: begin
                    // triggers mid-conversion are ignored
                    conv_cnt_q <= 6'(conv_cnt_q - 1'b1);
                    if (conv_end) begin
                        state_q <= adcr_pkg::ADCR_DONE;
                        done_cnt_q <= adcr_pkg::DONE_Q;
                    end
                end
                adcr_pkg::ADCR_DONE: begin
                    // a fresh trigger during the pulse starts at once
                    done_cnt_q <= 3'(done_cnt_q - 1'b1);
                    if (trig_rise) begin
                        state_q <= adcr_pkg::ADCR_CONV;
                        conv_cnt_q <= fast_grade ? adcr_pkg::CONV_FAST_Q
                                                 : adcr_pkg::CONV_STD_Q;
                    end else if (done_cnt_q == 3'h1) begin
                        state_q <= adcr_pkg::ADCR_IDLE;
                    end
                end
                default: begin
                    state_q <= adcr_pkg::ADCR_IDLE;
                end
            endcase
        end
    end

    // track/hold and done outputs, registered
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hold_q <= 1'b0;
            done_n <= 1'b1;
        end else begin
            if (trig_rise && state_q != adcr_pkg::ADCR_CONV) begin
                hold_q <= 1'b1;
            end else if (conv_end) begin
                hold_q <= 1'b0;
            end
            done_n <= !(conv_end
                || (state_q == adcr_pkg::ADCR_DONE && done_cnt_q != 3'h1
                    && !trig_rise));
        end
    end

    // output register, coding fixed by grade; held until next end
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            result_q <= adcr_pkg::RES_RESET;
        end else if (conv_end) begin
            // flipping the msb turns two's compl. into offset binary
            result_q <= unipolar_grade ? {~conv_result[11],
                                          conv_result[10:0]}
                                       : conv_result;
        end
    end

    // =====================================================
    // parallel port
    // outputs follow synchronised cs/rd, so a done-driven read
    // still sees the new word: it is loaded at the pulse start
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            par_data_o <= adcr_pkg::RES_RESET;
            par_data_oe <= 1'b0;
        end else begin
            par_data_o <= result_q;
            par_data_oe <= par_mode && !cs_s && !rd_s;
        end
    end

    // =====================================================
    // serial port
    logic [15:0] shreg_q; // frame being shifted
    logic [4:0] bits_q; // bits already presented
    logic active_q; // frame in progress
    logic done_frm_q; // all sixteen bits presented

    // frame and shift control; inactive in parallel mode
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            shreg_q <= 16'h0000;
            bits_q <= 5'h00;
            active_q <= 1'b0;
            done_frm_q <= 1'b0;
            serial_out_line_o <= 1'b0;
            serial_out_line_oe <= 1'b0;
        end else if (par_mode) begin
            active_q <= 1'b0;
            serial_out_line_oe <= 1'b0;
        end else if (frame_fall) begin
            // four leading zeros, then result msb first
            shreg_q <= {4'h0, result_q};
            bits_q <= 5'h00;
            active_q <= 1'b1;
            done_frm_q <= 1'b0;
            serial_out_line_o <= 1'b0;
            serial_out_line_oe <= 1'b1;
        end else if (active_q) begin
            if (frame_rise || (sclk_rise && done_frm_q)) begin
                active_q <= 1'b0;
                serial_out_line_oe <= 1'b0;
            end else if (sclk_rise && !frame_s) begin
                // next bit on each rising shift clock edge
                shreg_q <= {shreg_q[14:0], 1'b0};
                serial_out_line_o <= shreg_q[14];
                bits_q <= 5'(bits_q + 1'b1);
                if (5'(bits_q + 1'b1) == adcr_pkg::SER_FRAME - 5'h01) begin
                    done_frm_q <= 1'b1;
                end
            end
        end
    end

    // =====================================================
    // sample stream through the buffer
    logic fifo_in_ready;

    // flag a sample lost when the buffer is full; the flag sticks until reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            overrun_q <= 1'b0;
        end else if (conv_end && !fifo_in_ready) begin
            overrun_q <= 1'b1;
        end
    end

    adcr_fifo #(
        .WIDTH(adcr_pkg::RES_W),
        .DEPTH(adcr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .in_data(unipolar_grade ? {~conv_result[11], conv_result[10:0]}
                                : conv_result),
        .in_valid(conv_end),
        .in_ready(fifo_in_ready),
        .out_data(stream_data),
        .out_valid(stream_valid),
        .out_ready(stream_ready)
    );
endmodule : adcr_top

// [adcr_properties.sv]
// concurrent checks on the ports of the converter sequencer top
// assumes synchronous active high reset and one clk_sys domain
`timescale 1ns/1ps
module adcr_properties (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic fast_grade,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic done_n,
    input wire logic hold_q,
    input wire logic [11:0] par_data_o,
    input wire logic par_data_oe,
    input wire logic serial_out_line_o,
    input wire logic serial_out_line_oe,
    input wire logic [11:0] stream_data,
    input wire logic stream_valid,
    input wire logic stream_ready,
    input wire logic overrun_q
);
    // =========================================
    // conversion timing
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // hold rises at the edge that acts on the seen trigger; done falls
    // the counted conversion cycles after that same edge
    a_conv_fast: assert property (
        fast_grade && $rose(hold_q) |-> ##29 $fell(done_n))
        else $error("fast conversion length wrong");
    a_conv_std: assert property (
        !fast_grade && $rose(hold_q) |-> ##32 $fell(done_n))
        else $error("standard conversion length wrong");
    a_track_at_done: assert property (
        $fell(done_n) |-> !hold_q && $past(hold_q))
        else $error("done without hold to track");
    a_done_width: assert property (
        $fell(done_n) |=> !done_n ##1 done_n)
        else $error("done pulse not two cycles");
    // =========================================
    // readout ports
    // three flops of latency between pin and enable, one cycle of slack
    a_par_enable: assert property (
        par_data_oe |-> $past(!cs_n && !rd_n, 2)
            || $past(!cs_n && !rd_n, 3) || $past(!cs_n && !rd_n, 4))
        else $error("parallel drive without select");
    // the new word reaches the pins one edge after done falls, so the
    // sample one edge after that fall may differ from the one before
    a_par_held: assert property (
        par_data_oe && $past(par_data_oe)
            && !(!$past(done_n) && $past(done_n, 2))
            |-> $stable(par_data_o))
        else $error("result moved between conversions");
    a_ports_apart: assert property (
        !(par_data_oe && serial_out_line_oe))
        else $error("both readout ports driving");
    a_lead_zero: assert property (
        $rose(serial_out_line_oe) |-> !serial_out_line_o)
        else $error("serial frame not led by zero");
    // =========================================
    // sample stream
    a_stream_hold: assert property (
        stream_valid && !stream_ready |=> stream_valid
            && $stable(stream_data))
        else $error("stream head moved while stalled");
    a_overrun_stick: assert property (overrun_q |=> overrun_q)
        else $error("overrun flag dropped");
    a_reset_quiet: assert property (disable iff (1'b0)
        reset |=> done_n && !hold_q && !par_data_oe
            && !serial_out_line_oe)
        else $error("outputs active after reset");
endmodule : adcr_properties

bind adcr_top adcr_properties adcr_properties_i (
    .clk_sys(clk_sys),
    .reset(reset),
    .fast_grade(fast_grade),
    .cs_n(cs_n),
    .rd_n(rd_n),
    .done_n(done_n),
    .hold_q(hold_q),
    .par_data_o(par_data_o),
    .par_data_oe(par_data_oe),
    .serial_out_line_o(serial_out_line_o),
    .serial_out_line_oe(serial_out_line_oe),
    .stream_data(stream_data),
    .stream_valid(stream_valid),
    .stream_ready(stream_ready),
    .overrun_q(overrun_q)
);

// [adcr_host_model.sv]
// host side of the three-wire serial readout
// assumes reads are started only after the done pulse
`timescale 1ns/1ps
module adcr_host_model (
    input wire logic serial_out_line_o,
    input wire logic serial_out_line_oe,
    output logic shift_clk,
    output logic serial_frame_strobe_n
);
    // =========================================
    // wire level
    logic last_q; // last level while driven
    logic line; // resolved level, inverted when released so no stale value
    assign line = serial_out_line_oe ? serial_out_line_o : ~last_q;
    always @* if (serial_out_line_oe) last_q = serial_out_line_o;
    initial begin
        shift_clk = 1'b0; // clock stands still outside frames
        serial_frame_strobe_n = 1'b1;
    end
    // =========================================
    // one sixteen bit read, 400 ns clock, paused between bytes
    task automatic read_word(output logic [15:0] w, output logic rel);
        integer i;
        #13; // off the system clock edges
        serial_frame_strobe_n = 1'b0;
        #250;
        w[15] = line;
        for (i = 14; i >= 0; i--) begin
            if (i == 7) #900; // byte gap, clock idle low
            shift_clk = 1'b1;
            #200;
            shift_clk = 1'b0;
            w[i] = line; // slow clock: take bit on fall
            #200;
        end
        shift_clk = 1'b1; // this rise ends the read
        #200;
        rel = !serial_out_line_oe;
        shift_clk = 1'b0;
        #100;
        serial_frame_strobe_n = 1'b1;
    endtask : read_word
endmodule : adcr_host_model

// [tb_adcr_top.sv]
// self-checking bench for the converter sequencer and readout
// assumes adcr_top with its fifo and the serial host model
`timescale 1ns/1ps
module tb_adcr_top;
    logic clk_sys, reset, fast_grade, unipolar_grade, sample_trigger;
    logic mode_pin, cs_n, rd_n, shift_clk, serial_frame_strobe_n;
    logic stream_ready, done_n, hold_q, par_data_oe, serial_out_line_o;
    logic serial_out_line_oe, stream_valid, overrun_q, rel;
    logic [11:0] conv_result, par_data_o, stream_data, last_exp;
    logic [11:0] exp_q[$]; // accepted samples, oldest first
    logic [15:0] word;
    integer seed = 94283;
    integer n_mismatch = 0;
    integer samples_checked = 0;
    integer i;
    adcr_top adcr_top_i (
        .clk_sys(clk_sys),
        .reset(reset),
        .fast_grade(fast_grade),
        .unipolar_grade(unipolar_grade),
        .conv_result(conv_result),
        .sample_trigger(sample_trigger),
        .mode_pin(mode_pin),
        .cs_n(cs_n),
        .rd_n(rd_n),
        .shift_clk(shift_clk),
        .serial_frame_strobe_n(serial_frame_strobe_n),
        .done_n(done_n),
        .hold_q(hold_q),
        .par_data_o(par_data_o),
        .par_data_oe(par_data_oe),
        .serial_out_line_o(serial_out_line_o),
        .serial_out_line_oe(serial_out_line_oe),
        .stream_data(stream_data),
        .stream_valid(stream_valid),
        .stream_ready(stream_ready),
        .overrun_q(overrun_q)
    );
    adcr_host_model adcr_host_model_i (
        .serial_out_line_o(serial_out_line_o),
        .serial_out_line_oe(serial_out_line_oe),
        .shift_clk(shift_clk),
        .serial_frame_strobe_n(serial_frame_strobe_n)
    );
    // =========================================
    // helpers
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // unipolar grade flips the sign bit of the core word
    function automatic logic [11:0] coded(input logic [11:0] r, input logic u);
        return u ? {~r[11], r[10:0]} : r;
    endfunction : coded
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    // one conversion; entered just after a rising edge
    task automatic convert(input logic [11:0] r, input logic fg,
                           input logic ug, input logic again);
        time t0;
        integer k;
        t0 = $time;
        conv_result <= r;
        fast_grade <= fg;
        unipolar_grade <= ug;
        sample_trigger <= 1'b1;
        repeat (4) @(posedge clk_sys);
        sample_trigger <= 1'b0;
        if (again) begin // retrigger mid conversion must be ignored
            repeat (6) @(posedge clk_sys);
            sample_trigger <= 1'b1;
            repeat (4) @(posedge clk_sys);
            sample_trigger <= 1'b0;
        end
        for (k = 0; k < 80 && done_n !== 1'b0; k++) @(negedge clk_sys);
        if (k == 80) begin
            n_mismatch++;
            close_out();
        end
        check(hold_q, 0);
        check(16'(($time - t0 - 25) / 50), fg ? 16'h0020 : 16'h0023);
        last_exp = coded(r, ug);
        if (exp_q.size() < 32) exp_q.push_back(last_exp);
        repeat (8) @(posedge clk_sys); // acquisition gap
    endtask : convert
    task automatic par_read(input logic [11:0] want);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        check(par_data_oe, 1);
        check(par_data_o, want);
        @(posedge clk_sys);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        check(par_data_oe, 0);
        @(posedge clk_sys);
    endtask : par_read
    // =========================================
    // main sequence
    initial begin
        reset = 1'b1;
        fast_grade = 1'b0;
        unipolar_grade = 1'b0;
        conv_result = 12'h000;
        sample_trigger = 1'b0;
        mode_pin = 1'b1;
        cs_n = 1'b1;
        rd_n = 1'b1;
        stream_ready = 1'b0;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(negedge clk_sys);
        check(done_n, 1);
        check(stream_valid, 0);
        repeat (3) @(posedge clk_sys);
        // fill the stalled fifo past its depth, reading each result
        for (i = 0; i < 33; i++) begin
            convert(i == 0 ? 12'h800 : 12'($random(seed)), i[0],
                    1'($random(seed)), i == 3);
            par_read(last_exp);
            if (i == 0) par_read(last_exp); // repeat read
        end
        check(overrun_q, 1);
        $display("test parallel and fill done");
        for (i = 0; i < 32; i++) begin
            @(negedge clk_sys);
            check(stream_valid, 1);
            check(stream_data, exp_q[i]);
            @(posedge clk_sys);
            stream_ready <= 1'b1;
            @(posedge clk_sys);
            stream_ready <= 1'b0;
        end
        @(negedge clk_sys);
        check(stream_valid, 0);
        $display("test drain done");
        @(posedge clk_sys);
        mode_pin <= 1'b0;
        stream_ready <= 1'b1;
        for (i = 0; i < 4; i++) begin
            convert(i == 0 ? 12'hFFF : 12'($random(seed)),
                    1'($random(seed)), 1'($random(seed)), 1'b0);
            adcr_host_model_i.read_word(word, rel); // after done only
            check(word, {4'h0, last_exp});
            check(rel, 1);
            // keep the read well clear of the next trigger
            repeat (9) @(posedge clk_sys);
        end
        $display("test serial done");
        close_out();
    end
endmodule : tb_adcr_top
